// *** inc/ssa_pkg.sv ***
// Constants of the SMI status aggregator: offsets, bit positions, reset values.
// Assumes the host reaches the block through a PCI I/O window at smi_status_base.
//
// Operation
// RULE1 - Reading clearing top status clears all read-to-clear bits, not read-only ones
// RULE2 - Clearing a second-level bit also clears its top-level bit, GPIO excepted
// RULE3 - GPIO sources have third level; clearing it clears second and top levels
// RULE4 - Top status mirror reads same value, clears nothing, keeps SMI asserted
// RULE5 - Bit 15 mirrors suspend-modulation configuration bit, read-to-clear
// RULE6 - Bit 14 flags USB SMI, read-to-clear, only when both USB enables are set
// RULE7 - Bits 13, 12, 11 flag warm reset, NMI, legacy IRQ2; read-to-clear
// RULE8 - Bit 10 flags falling edge on external SMI inputs; read-only, second level held
// RULE9 - Bit 9 flags timer or trap SMIs; read-only, detail in trap/timer status
// RULE10 - Bit 8 flags software SMI, cleared by reading clearing status register
// RULE11 - Bit 7 flags port 92h or keyboard address-bit-20 SMI, enabled, read-to-clear
// RULE12 - Bit 6 flags VGA timer expiry when enabled, read-to-clear
// RULE13 - Bit 5 flags retrace from serial link bit 7 when enabled, read-to-clear
// RULE14 - Bit 4 reserved, always reads zero
// RULE15 - Bit 3 flags LPC SMI from two second-level bits; read-only
// RULE16 - Bit 2 flags ACPI register access SMI; read-only, detail at second level
// RULE17 - Bit 1 flags audio SMI; read-only, detail in audio registers
// RULE18 - Bit 0 flags other power-management SMIs; read-only
// RULE19 - Trap/timer status mirror resets to zero, read clears nothing, bits 15:6 zero
// RULE20 - Bit 5 flags configuration trap, enabled per legacy space and functions one-five
// RULE21 - Bits 4, 3, 2 flag user traps three, two, one, each enabled
// RULE22 - Bits 1, 0 flag timers two and one expiry, each enabled
// RULE23 - Read-only top bits are OR of second level; SMI held while any set
package ssa_pkg;
  localparam logic [7:0] OFS_TOP_MIRROR = 8'h00;
  localparam logic [7:0] OFS_TOP_CLEARING = 8'h02;
  localparam logic [7:0] OFS_TRAP_MIRROR = 8'h04;
  localparam logic [15:0] TOP_RESET = 16'h0000;
  localparam logic [15:0] TRAP_RESET = 16'h0000;
  localparam logic [15:0] TOP_RC_MASK = 16'hF9E0;
  localparam logic [15:0] TRAP_RSVD_MASK = 16'hFFC0;
  localparam logic [1:0] USB_EN_BOTH = 2'b11;
  localparam int BIT_SUSP = 15;
  localparam int BIT_USB = 14;
  localparam int BIT_WARM = 13;
  localparam int BIT_NMI = 12;
  localparam int BIT_IRQ2 = 11;
  localparam int BIT_EXT = 10;
  localparam int BIT_TRAP = 9;
  localparam int BIT_SW = 8;
  localparam int BIT_A20 = 7;
  localparam int BIT_VGA = 6;
  localparam int BIT_RETRACE = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_LPC = 3;
  localparam int BIT_ACPI = 2;
  localparam int BIT_AUDIO = 1;
  localparam int BIT_PME = 0;
  localparam int LINK_RETRACE_BIT = 7;
  localparam int TRAP_BIT_CFG = 5;
endpackage

// *** rtl/ssa_ext_edge.sv ***
// Falling-edge detection and second-level status of the external SMI inputs.
// Assumes inputs are synchronous to i_ref_clk and idle high.
`timescale 1ns/1ps
module ssa_ext_edge #(
  parameter int N = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [N-1:0] i_external_smi_inputs,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_status
);
  logic [N-1:0] prev_q;
  logic [N-1:0] stat_q;
  wire [N-1:0] fall = prev_q & ~i_external_smi_inputs;

  ////////////////////////////////////////////////////////////////////////////
  // Per-input edge and sticky status, set wins over clear
  for (genvar g = 0; g < N; g++) begin : g_in
    always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
        prev_q[g] <= 1'b1;
        stat_q[g] <= 1'b0;
      end else begin
        prev_q[g] <= i_external_smi_inputs[g];
        stat_q[g] <= fall[g] | (stat_q[g] & ~i_clr[g]); // [RULE8]
      end
    end
  end

  assign o_status = stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ext_fall;
    @(posedge i_ref_clk) disable iff (i_reset)
      (|fall) |=> ((o_status & $past(fall)) == $past(fall));
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("edge not latched"); // [RULE8]
endmodule

// *** rtl/ssa_trap_status.sv ***
// Second-level general trap and timer status with its non-clearing view.
// Assumes event inputs are one-cycle pulses; i_clr comes from the i_trap_clr input of ssa_top.
`timescale 1ns/1ps
module ssa_trap_status (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [5:0] i_cfg_trap_evt,
  input wire logic [5:0] i_cfg_trap_en,
  input wire logic [2:0] i_user_trap_evt,
  input wire logic [2:0] i_user_trap_en,
  input wire logic [1:0] i_timer_evt,
  input wire logic [1:0] i_timer_en,
  input wire logic i_clr,
  output logic [15:0] o_status
);
  localparam logic [15:0] TRAP_RESET = ssa_pkg::TRAP_RESET;
  logic [5:0] stat_q;
  wire cfg_hit = |(i_cfg_trap_evt & i_cfg_trap_en); // [RULE20]
  wire [2:0] udef_hit = i_user_trap_evt & i_user_trap_en; // [RULE21]
  wire [1:0] tmr_hit = i_timer_evt & i_timer_en; // [RULE22]
  wire [5:0] set = {cfg_hit, udef_hit, tmr_hit};

  ////////////////////////////////////////////////////////////////////////////
  // Sticky bits, set wins over clear
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      stat_q <= TRAP_RESET[5:0]; // [RULE19]
    end else begin
      stat_q <= set | (stat_q & ~{6{i_clr}});
    end
  end

  assign o_status = {10'h000, stat_q}; // [RULE19]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trap_rsvd;
    @(posedge i_ref_clk) disable iff (i_reset)
      (o_status & ssa_pkg::TRAP_RSVD_MASK) == 16'h0000;
  endproperty
  a_trap_rsvd: assert property (p_trap_rsvd) else $error("reserved trap bits set"); // [RULE19]

  property p_timer_gate;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_timer_evt[0] && !i_timer_en[0] && !o_status[0]) |=> !o_status[0];
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer one ungated"); // [RULE22]

  property p_udef_set;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_user_trap_evt[2] && i_user_trap_en[2]) |=> o_status[4];
  endproperty
  a_udef_set: assert property (p_udef_set) else $error("user trap three lost"); // [RULE21]

  property p_cfg_set;
    @(posedge i_ref_clk) disable iff (i_reset)
      (|(i_cfg_trap_evt & i_cfg_trap_en)) |=> o_status[ssa_pkg::TRAP_BIT_CFG];
  endproperty
  a_cfg_set: assert property (p_cfg_set) else $error("config trap lost"); // [RULE20]
endmodule

// *** rtl/ssa_top.sv ***
// Top-level SMI status aggregation with its I/O register window.
// Assumes single clock and one-cycle pulse sources; base decode compares i_io_addr[15:8] with i_smi_status_base.
`timescale 1ns/1ps
module ssa_top (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_smi_status_base,
  input wire logic i_io_space_en,
  output logic [15:0] o_io_rdata,
  output logic o_io_ack,
  input wire logic i_susp_mod_cfg,
  input wire logic i_usb_evt,
  input wire logic [1:0] i_usb_smi_en,
  input wire logic i_warm_reset_evt,
  input wire logic i_nmi_evt,
  input wire logic i_irq2_evt,
  input wire logic i_irq2_l2_clr,
  input wire logic i_sw_smi_evt,
  input wire logic i_address_bit20_mask_evt,
  input wire logic i_a20_smi_en,
  input wire logic i_vga_timer_evt,
  input wire logic i_vga_smi_en,
  input wire logic [7:0] i_processor_serial_link_reg,
  input wire logic i_retrace_smi_en,
  input wire logic [7:0] i_external_smi_inputs,
  input wire logic [7:0] i_ext_clr,
  input wire logic [5:0] i_cfg_trap_evt,
  input wire logic [5:0] i_cfg_trap_en,
  input wire logic [2:0] i_user_trap_evt,
  input wire logic [2:0] i_user_trap_en,
  input wire logic [1:0] i_timer_evt,
  input wire logic [1:0] i_timer_en,
  input wire logic i_trap_clr,
  input wire logic [1:0] i_lpc_status,
  input wire logic [5:0] i_acpi_status,
  input wire logic i_audio_smi,
  input wire logic i_power_mgmt_event,
  input wire logic [7:0] i_gpio_l3_status,
  output logic o_smi_req
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] rc_q;
  logic [15:0] rc_d;
  logic susp_prev_q;
  logic link7_prev_q;
  logic gpio_l2_q;
  logic [15:0] rdata_q;
  logic ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Second-level blocks
  logic [7:0] ext_status;
  logic [15:0] trap_status;

  ssa_ext_edge #(
    .N(8)
  ) u_ext (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_external_smi_inputs(i_external_smi_inputs),
    .i_clr(i_ext_clr),
    .o_status(ext_status)
  );

  ssa_trap_status u_trap (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_cfg_trap_evt(i_cfg_trap_evt),
    .i_cfg_trap_en(i_cfg_trap_en),
    .i_user_trap_evt(i_user_trap_evt),
    .i_user_trap_en(i_user_trap_en),
    .i_timer_evt(i_timer_evt),
    .i_timer_en(i_timer_en),
    .i_clr(i_trap_clr),
    .o_status(trap_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register window decode
  wire rd_hit = i_io_rd & i_io_space_en & (i_io_addr[15:8] == i_smi_status_base);
  wire [7:0] ofs = i_io_addr[7:0];
  wire rd_mirror = rd_hit & (ofs == ssa_pkg::OFS_TOP_MIRROR);
  wire rd_clearing = rd_hit & (ofs == ssa_pkg::OFS_TOP_CLEARING);
  wire rd_trap = rd_hit & (ofs == ssa_pkg::OFS_TRAP_MIRROR);

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification for read-to-clear bits
  wire susp_set = i_susp_mod_cfg & ~susp_prev_q; // [RULE5]
  wire usb_set = i_usb_evt & (i_usb_smi_en == ssa_pkg::USB_EN_BOTH); // [RULE6]
  wire a20_set = i_address_bit20_mask_evt & i_a20_smi_en; // [RULE11]
  wire vga_set = i_vga_timer_evt & i_vga_smi_en; // [RULE12]
  wire link7 = i_processor_serial_link_reg[ssa_pkg::LINK_RETRACE_BIT];
  wire retrace_set = link7 & ~link7_prev_q & i_retrace_smi_en; // [RULE13]

  wire [15:0] rc_set;
  assign rc_set[ssa_pkg::BIT_SUSP] = susp_set;
  assign rc_set[ssa_pkg::BIT_USB] = usb_set;
  assign rc_set[ssa_pkg::BIT_WARM] = i_warm_reset_evt; // [RULE7]
  assign rc_set[ssa_pkg::BIT_NMI] = i_nmi_evt; // [RULE7]
  assign rc_set[ssa_pkg::BIT_IRQ2] = i_irq2_evt; // [RULE7]
  assign rc_set[ssa_pkg::BIT_EXT] = 1'b0;
  assign rc_set[ssa_pkg::BIT_TRAP] = 1'b0;
  assign rc_set[ssa_pkg::BIT_SW] = i_sw_smi_evt; // [RULE10]
  assign rc_set[ssa_pkg::BIT_A20] = a20_set;
  assign rc_set[ssa_pkg::BIT_VGA] = vga_set;
  assign rc_set[ssa_pkg::BIT_RETRACE] = retrace_set;
  assign rc_set[4:0] = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Clear sources: clearing read, legacy IRQ2 second level
  wire [15:0] irq2_clr_vec = {4'h0, i_irq2_l2_clr, 11'h000}; // [RULE2]
  wire [15:0] rd_clr_vec = {16{rd_clearing}}; // [RULE1] [RULE10]
  wire [15:0] rc_clr = (rd_clr_vec | irq2_clr_vec) & ssa_pkg::TOP_RC_MASK;

  assign rc_d = (rc_set | (rc_q & ~rc_clr)) & ssa_pkg::TOP_RC_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Read-only top bits built from second level
  wire gpio_any = |i_gpio_l3_status;
  wire ext_any = |ext_status; // [RULE8] [RULE23]
  wire trap_any = |trap_status; // [RULE9] [RULE23]
  wire lpc_any = |i_lpc_status; // [RULE15]
  wire acpi_any = |i_acpi_status; // [RULE16]
  wire pme_any = i_power_mgmt_event | gpio_l2_q; // [RULE18] [RULE3]

  wire [15:0] ro_view;
  assign ro_view[15:11] = 5'h00;
  assign ro_view[ssa_pkg::BIT_EXT] = ext_any;
  assign ro_view[ssa_pkg::BIT_TRAP] = trap_any;
  assign ro_view[8:5] = 4'h0;
  assign ro_view[ssa_pkg::BIT_RSVD] = 1'b0; // [RULE14]
  assign ro_view[ssa_pkg::BIT_LPC] = lpc_any;
  assign ro_view[ssa_pkg::BIT_ACPI] = acpi_any;
  assign ro_view[ssa_pkg::BIT_AUDIO] = i_audio_smi; // [RULE17]
  assign ro_view[ssa_pkg::BIT_PME] = pme_any;

  wire [15:0] top_view = rc_q | ro_view; // [RULE23]

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  wire sel_top = rd_mirror | rd_clearing; // [RULE4]
  wire [15:0] rd_mux = sel_top ? top_view : (rd_trap ? trap_status : 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Status and edge history
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rc_q <= ssa_pkg::TOP_RESET;
      susp_prev_q <= 1'b0;
      link7_prev_q <= 1'b0;
      gpio_l2_q <= 1'b0;
    end else begin
      rc_q <= rc_d;
      susp_prev_q <= i_susp_mod_cfg;
      link7_prev_q <= link7;
      gpio_l2_q <= gpio_any; // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_hit;
      if (rd_hit) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign o_io_rdata = rdata_q;
  assign o_io_ack = ack_q;
  assign o_smi_req = |top_view; // [RULE23]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_clearing_read;
    rd_clearing && (rc_set == 16'h0000) && !i_irq2_evt;
  endsequence

  sequence s_rc_empty;
    (rc_q & ssa_pkg::TOP_RC_MASK) == 16'h0000;
  endsequence

  property p_rc_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
      s_clearing_read |=> s_rc_empty;
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("clearing read left bits"); // [RULE1]

  property p_mirror_keep;
    @(posedge i_ref_clk) disable iff (i_reset)
      (rd_mirror && !i_irq2_l2_clr) |=> ((rc_q & $past(rc_q)) == $past(rc_q));
  endproperty
  a_mirror_keep: assert property (p_mirror_keep) else $error("mirror read cleared"); // [RULE4]

  sequence s_mirror_read;
    rd_mirror ##1 o_io_ack;
  endsequence

  property p_mirror_data;
    @(posedge i_ref_clk) disable iff (i_reset)
      s_mirror_read |-> (o_io_rdata == $past(top_view));
  endproperty
  a_mirror_data: assert property (p_mirror_data) else $error("mirror data wrong"); // [RULE4]

  property p_rsvd_zero;
    @(posedge i_ref_clk) disable iff (i_reset)
      (rd_mirror || rd_clearing) |=> !o_io_rdata[ssa_pkg::BIT_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read one"); // [RULE14]

  property p_usb_gate;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_usb_evt && (i_usb_smi_en != 2'b11) && !rc_q[ssa_pkg::BIT_USB])
        |=> !rc_q[ssa_pkg::BIT_USB];
  endproperty
  a_usb_gate: assert property (p_usb_gate) else $error("usb ungated"); // [RULE6]

  property p_retrace;
    @(posedge i_ref_clk) disable iff (i_reset)
      ($rose(link7) && i_retrace_smi_en) |=> rc_q[ssa_pkg::BIT_RETRACE];
  endproperty
  a_retrace: assert property (p_retrace) else $error("retrace lost"); // [RULE13]

  property p_set_wins;
    @(posedge i_ref_clk) disable iff (i_reset)
      (rd_clearing && i_sw_smi_evt) |=> rc_q[ssa_pkg::BIT_SW];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("software smi lost"); // [RULE10]

  property p_ext_top;
    @(posedge i_ref_clk) disable iff (i_reset)
      rd_clearing && (|ext_status) |=> ##1 o_smi_req || !(|ext_status);
  endproperty
  a_ext_top: assert property (p_ext_top) else $error("ext bit cleared by read"); // [RULE8]

  property p_smi_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
      (rc_q[ssa_pkg::BIT_NMI] && !rd_clearing) |=> o_smi_req;
  endproperty
  a_smi_hold: assert property (p_smi_hold) else $error("smi dropped"); // [RULE23]

  property p_susp;
    @(posedge i_ref_clk) disable iff (i_reset)
      $rose(i_susp_mod_cfg) |=> rc_q[ssa_pkg::BIT_SUSP];
  endproperty
  a_susp: assert property (p_susp) else $error("suspend mirror missed"); // [RULE5]
endmodule

// *** tb/ssa_host.sv ***
// Host side of the SMI status window: issues single word reads.
// Assumes a one-cycle read strobe and an ack one cycle after the hit.
`timescale 1ns/1ps
module ssa_host (
  input wire logic i_ref_clk,
  output logic o_io_rd,
  output logic [15:0] o_io_addr,
  input wire logic [15:0] i_io_rdata,
  input wire logic i_io_ack
);
  initial begin
    o_io_rd = 1'b0;
    o_io_addr = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One read; ok stays low when no ack comes within four cycles
  task automatic rd(input logic [15:0] addr, output logic [15:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 16'h0000;
    @(posedge i_ref_clk);
    #1;
    o_io_rd = 1'b1;
    o_io_addr = addr;
    @(posedge i_ref_clk);
    #1;
    o_io_rd = 1'b0;
    for (n = 0; n < 4 && ok !== 1'b1; n++) begin
      @(posedge i_ref_clk);
      if (i_io_ack === 1'b1) begin
        ok = 1'b1;
        data = i_io_rdata;
      end
    end
    // Released address stops showing the old value
    o_io_addr = ~addr;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the SMI status aggregator.
// Assumes the host model does all register reads; sources are driven here.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, space_en = 1'b1, susp = 1'b0, usb = 1'b0, warm = 1'b0;
  logic nmi = 1'b0, irq2 = 1'b0, irq2_clr = 1'b0, sw = 1'b0, a20 = 1'b0, a20_en = 1'b0;
  logic vga = 1'b0, vga_en = 1'b0, ret_en = 1'b0, trap_clr = 1'b0, audio = 1'b0, power_mgmt_event = 1'b0;
  logic [1:0] usb_en = 2'b00, lpc = 2'b00;
  logic [7:0] base = 8'h9C, link = 8'h00, ext = 8'hFF, ext_clr = 8'h00, gpio = 8'h00;
  logic [5:0] acpi = 6'h00;
  logic [10:0] tevt = 11'h000, ten = 11'h000;
  logic io_rd, io_ack, smi;
  logic [15:0] io_addr, rdata;
  int mismatches = 0, n_checks = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  ssa_host u_host (.i_ref_clk(clk), .o_io_rd(io_rd), .o_io_addr(io_addr),
    .i_io_rdata(rdata), .i_io_ack(io_ack));

  ssa_top u_dut (.i_ref_clk(clk), .i_reset(rst), .i_io_rd(io_rd), .i_io_addr(io_addr),
    .i_smi_status_base(base), .i_io_space_en(space_en), .o_io_rdata(rdata),
    .o_io_ack(io_ack), .i_susp_mod_cfg(susp), .i_usb_evt(usb), .i_usb_smi_en(usb_en),
    .i_warm_reset_evt(warm), .i_nmi_evt(nmi), .i_irq2_evt(irq2), .i_irq2_l2_clr(irq2_clr),
    .i_sw_smi_evt(sw), .i_address_bit20_mask_evt(a20), .i_a20_smi_en(a20_en),
    .i_vga_timer_evt(vga), .i_vga_smi_en(vga_en), .i_processor_serial_link_reg(link),
    .i_retrace_smi_en(ret_en), .i_external_smi_inputs(ext), .i_ext_clr(ext_clr),
    .i_cfg_trap_evt(tevt[5:0]), .i_cfg_trap_en(ten[5:0]), .i_user_trap_evt(tevt[8:6]),
    .i_user_trap_en(ten[8:6]), .i_timer_evt(tevt[10:9]), .i_timer_en(ten[10:9]),
    .i_trap_clr(trap_clr), .i_lpc_status(lpc), .i_acpi_status(acpi), .i_audio_smi(audio),
    .i_power_mgmt_event(power_mgmt_event), .i_gpio_l3_status(gpio), .o_smi_req(smi));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  task rdc(input logic [7:0] off, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host.rd({base, off}, d, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t read not acknowledged", $time);
      close_out;
    end else begin
      chk(d, exp);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rdc(8'h00, 16'h0000);
    rdc(8'h02, 16'h0000);
    rdc(8'h04, 16'h0000);
    chk_bit(smi, 1'b0);
  endtask

  task t_rc;
    usb_en = 2'b11; a20_en = 1'b1; vga_en = 1'b1; ret_en = 1'b1; susp = 1'b1;
    {usb, warm, nmi, irq2, sw, a20, vga} = 7'h7F; link = 8'h80;
    tick;
    {usb, warm, nmi, irq2, sw, a20, vga} = 7'h00;
    tick;
    rdc(8'h00, 16'hF9E0);
    rdc(8'h00, 16'hF9E0);
    chk_bit(smi, 1'b1);
    rdc(8'h02, 16'hF9E0);
    rdc(8'h02, 16'h0000);
    chk_bit(smi, 1'b0);
    link = 8'h00; susp = 1'b0;
    tick;
  endtask

  task t_gate;
    usb_en = 2'b01; a20_en = 1'b0; vga_en = 1'b0; ret_en = 1'b0;
    {usb, a20, vga} = 3'h7; link = 8'h80;
    tick;
    {usb, a20, vga} = 3'h0;
    tick;
    rdc(8'h00, 16'h0000);
    link = 8'h00;
  endtask

  task t_ro;
    for (int i = 0; i < 4; i++) begin
      lpc = (i == 0) ? 2'b01 : 2'b00; acpi = (i == 1) ? 6'h20 : 6'h00;
      audio = (i == 2); power_mgmt_event = (i == 3);
      tick;
      rdc(8'h02, 16'h0008 >> i);
      rdc(8'h02, 16'h0008 >> i);
      lpc = 2'b00; acpi = 6'h00; audio = 1'b0; power_mgmt_event = 1'b0;
      tick;
      rdc(8'h00, 16'h0000);
    end
  endtask

  task t_trap;
    logic [15:0] e;
    for (int i = 0; i < 11; i++) begin
      e = (i < 6) ? 16'h0020 : (i < 9) ? (16'h0004 << (i - 6)) : (16'h0001 << (i - 9));
      ten = ~(11'h001 << i); tevt = 11'h001 << i;
      tick;
      tevt = 11'h000;
      tick;
      rdc(8'h04, 16'h0000);
      ten = 11'h001 << i; tevt = 11'h001 << i;
      tick;
      tevt = 11'h000;
      tick;
      rdc(8'h04, e);
      rdc(8'h02, 16'h0200);
      rdc(8'h00, 16'h0200);
      trap_clr = 1'b1;
      tick;
      trap_clr = 1'b0;
      tick;
      rdc(8'h04, 16'h0000);
      rdc(8'h00, 16'h0000);
    end
  endtask

  task t_ext;
    for (int j = 0; j < 8; j++) begin
      ext[j] = 1'b0;
      tick;
      rdc(8'h02, 16'h0400);
      rdc(8'h02, 16'h0400);
      ext[j] = 1'b1; ext_clr[j] = 1'b1;
      tick;
      ext_clr = 8'h00;
      tick;
      rdc(8'h00, 16'h0000);
    end
  endtask

  task t_irq2_gpio;
    irq2 = 1'b1;
    tick;
    irq2 = 1'b0;
    rdc(8'h00, 16'h0800);
    irq2_clr = 1'b1;
    tick;
    irq2_clr = 1'b0;
    tick;
    rdc(8'h00, 16'h0000);
    gpio = 8'h10;
    tick;
    tick;
    rdc(8'h02, 16'h0001);
    rdc(8'h00, 16'h0001);
    gpio = 8'h00;
    tick;
    tick;
    rdc(8'h00, 16'h0000);
    chk_bit(smi, 1'b0);
  endtask

  task t_miss;
    logic [15:0] d;
    logic ok;
    sw = 1'b1;
    tick;
    sw = 1'b0;
    u_host.rd({~base, 8'h02}, d, ok);
    chk_bit(ok, 1'b0);
    #1;
    space_en = 1'b0;
    u_host.rd({base, 8'h02}, d, ok);
    chk_bit(ok, 1'b0);
    #1;
    space_en = 1'b1;
    rdc(8'h06, 16'h0000);
    rdc(8'h02, 16'h0100);
    rdc(8'h02, 16'h0000);
    // Software event in the same cycle as a clearing read
    fork
      u_host.rd({base, 8'h02}, d, ok);
      begin
        tick;
        sw = 1'b1;
        tick;
        sw = 1'b0;
      end
    join
    chk_bit(ok, 1'b1);
    chk(d, 16'h0000);
    #1;
    rdc(8'h02, 16'h0100);
    rdc(8'h02, 16'h0000);
  endtask

  task t_rst;
    nmi = 1'b1;
    tick;
    nmi = 1'b0;
    chk_bit(smi, 1'b1);
    rst = 1'b1;
    tick;
    tick;
    rst = 1'b0;
    rdc(8'h00, 16'h0000);
    rdc(8'h04, 16'h0000);
    chk_bit(smi, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_rc;
    t_gate;
    t_ro;
    t_trap;
    t_ext;
    t_irq2_gpio;
    t_miss;
    t_rst;
    close_out;
  end
endmodule
